/* cpmc_defs.vh */
`ifndef CPMC_DEFS_VH
`define CPMC_DEFS_VH

// ************************************************************
// Register offsets
// ************************************************************
`define CPMC_ADDR_W         10
`define CPMC_OFS_PLL_CTRL   10'h010
`define CPMC_OFS_CAL_CTRL   10'h018
`define CPMC_OFS_REF_CTRL   10'h01C
`define CPMC_OFS_DIV_RATIO  10'h1E0
`define CPMC_OFS_SRC_ROUTE  10'h1E1
`define CPMC_OFS_XFER       10'h232

// ************************************************************
// Field positions
// ************************************************************
`define CPMC_PWR_MSB        1
`define CPMC_PWR_LSB        0
`define CPMC_POL_BIT        7
`define CPMC_CAL_BIT        0
`define CPMC_REF_MSB        2
`define CPMC_REF_LSB        0
`define CPMC_DIV_MSB        2
`define CPMC_DIV_LSB        0
`define CPMC_SRC_VCO_BIT    1
`define CPMC_BYP_BIT        0
`define CPMC_XFER_BIT       0

// ************************************************************
// Encodings and reset values
// ************************************************************
`define CPMC_PWR_NORMAL     2'h0
`define CPMC_PWR_DOWN       2'h1
`define CPMC_RST_PLL_CTRL   8'h01
`define CPMC_RST_CAL_CTRL   8'h00
`define CPMC_RST_REF_CTRL   8'h00
`define CPMC_RST_DIV_RATIO  8'h00
`define CPMC_RST_SRC_ROUTE  8'h00

// ************************************************************
// Timing
// ************************************************************
`define CPMC_CAL_PULSE_CYC  1

`endif

/* cpmc_div_ratio.v */
`timescale 1ns/100ps
`default_nettype none

// ************************************************************
// Divider encoding decode
// ************************************************************
module cpmc_div_ratio (
  // Encoded field
  input  wire [2:0] i_code,
  // Decoded ratio
  output reg  [2:0] o_ratio
);

  // Code 000 gives two; 001..101 give 1,3,4,5,6; rest fall to two
  always @* begin
    case (i_code)
      3'h0:    o_ratio = 3'h2;
      3'h1:    o_ratio = 3'h1;
      3'h2:    o_ratio = 3'h3;
      3'h3:    o_ratio = 3'h4;
      3'h4:    o_ratio = 3'h5;
      3'h5:    o_ratio = 3'h6;
      default: o_ratio = 3'h2;
    endcase
  end

endmodule

`default_nettype wire

/* cpmc_clock_path.v */
// Behaviour
// R1: Power field 00 runs PLL normally; 01 powers it down asynchronously.
// R2: Polarity bit 0 selects positive, 1 selects negative detector polarity.
// R3: Source bit 1 selects on-chip VCO, 0 selects external clock input.
// R4: Bypass bit 0 feeds distribution from divider; 1 routes around divider.
// R5: Three-bit divider field gives ratio 1 to 6; code 000 means two.
// R6: Reset leaves PLL off, external clock, divider in path, code 000.
// R7: Calibration bit set then transfer strobe starts a VCO calibration.
// R8: Recalibration needs bit cleared and strobed, then set and strobed.
// R9: Software keeps channel divider input within its frequency limits.
// R10: PLL on with external source powers off VCO, feeds prescaler directly.
// R11: With external VCO, software sets power field to normal operation.
// R12: Software enables a reference input whenever the PLL runs.
// R13: Configuration can be saved to and restored from nonvolatile store.
// R14: Writes stage in a shadow copy, becoming active on transfer strobe.
`include "cpmc_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module cpmc_clock_path (
  // Clock, reset, enable
  input  wire                     i_core_clk,
  input  wire                     i_reset,
  input  wire                     i_clk_en,
  // Register port (from serial port logic, same clock)
  input  wire [`CPMC_ADDR_W-1:0]  i_addr,
  input  wire                     i_wr,
  input  wire [7:0]               i_wdata,
  output reg  [7:0]               o_rdata,
  // Nonvolatile store interface
  input  wire                     i_nv_save,
  input  wire                     i_nv_load,
  input  wire [39:0]              i_nv_rdata,
  output reg  [39:0]              o_nv_wdata,
  output reg                      o_nv_we,
  // Clock path controls
  output reg                      o_pll_on,
  output reg                      o_pll_async_pd,
  output reg                      o_pfd_neg,
  output reg                      o_src_vco,
  output reg                      o_div_bypass,
  output reg  [2:0]               o_div_ratio,
  output reg  [2:0]               o_ref_en,
  output reg                      o_vco_pd,
  output reg                      o_ext_to_prescaler,
  output reg                      o_cal_start,
  output reg                      o_cal_armed
);

  // ************************************************************
  // Staging and active register copies
  // ************************************************************
  reg  [7:0] stg_pll;
  reg  [7:0] stg_cal;
  reg  [7:0] stg_ref;
  reg  [7:0] stg_div;
  reg  [7:0] stg_src;
  reg  [7:0] act_pll;
  reg  [7:0] act_cal;
  reg  [7:0] act_ref;
  reg  [7:0] act_div;
  reg  [7:0] act_src;
  reg        cal_done_arm;
  wire       xfer;
  wire [2:0] dec_ratio;
  wire [1:0] act_pwr;

  assign xfer    = i_wr && (i_addr == `CPMC_OFS_XFER) && i_wdata[`CPMC_XFER_BIT];
  assign act_pwr = act_pll[`CPMC_PWR_MSB:`CPMC_PWR_LSB];

  // Staging writes; nonvolatile load restores the staging copy too
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      stg_pll <= `CPMC_RST_PLL_CTRL; // [R6]
      stg_cal <= `CPMC_RST_CAL_CTRL;
      stg_ref <= `CPMC_RST_REF_CTRL;
      stg_div <= `CPMC_RST_DIV_RATIO; // [R6]
      stg_src <= `CPMC_RST_SRC_ROUTE; // [R6]
    end else if (i_clk_en) begin
      if (i_nv_load) begin
        {stg_src, stg_div, stg_ref, stg_cal, stg_pll} <= i_nv_rdata; // [R13]
      end else if (i_wr) begin
        case (i_addr)
          `CPMC_OFS_PLL_CTRL:  stg_pll <= i_wdata;
          `CPMC_OFS_CAL_CTRL:  stg_cal <= i_wdata;
          `CPMC_OFS_REF_CTRL:  stg_ref <= i_wdata;
          `CPMC_OFS_DIV_RATIO: stg_div <= i_wdata;
          `CPMC_OFS_SRC_ROUTE: stg_src <= i_wdata;
          default: begin
          end
        endcase
      end
    end
  end

  // Active copy follows staging on the strobe, or straight after a restore
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      act_pll <= `CPMC_RST_PLL_CTRL;
      act_cal <= `CPMC_RST_CAL_CTRL;
      act_ref <= `CPMC_RST_REF_CTRL;
      act_div <= `CPMC_RST_DIV_RATIO;
      act_src <= `CPMC_RST_SRC_ROUTE;
    end else if (i_clk_en) begin
      if (i_nv_load) begin
        {act_src, act_div, act_ref, act_cal, act_pll} <= i_nv_rdata; // [R13]
      end else if (xfer) begin
        act_pll <= stg_pll; // [R14]
        act_cal <= stg_cal;
        act_ref <= stg_ref;
        act_div <= stg_div;
        act_src <= stg_src;
      end
    end
  end

  // Calibration fires only when the bit is active as 1 after having been 0.
  // The first calibration after reset is allowed because reset clears it.
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_cal_start  <= 1'b0;
      cal_done_arm <= 1'b1;
    end else if (i_clk_en) begin
      o_cal_start <= 1'b0;
      if (xfer) begin
        if (stg_cal[`CPMC_CAL_BIT] && cal_done_arm) begin
          o_cal_start  <= 1'b1; // [R7]
          cal_done_arm <= 1'b0;
        end else if (!stg_cal[`CPMC_CAL_BIT]) begin
          cal_done_arm <= 1'b1; // [R8]
        end
      end
    end
  end

  cpmc_div_ratio u_div (
    .i_code  (act_div[`CPMC_DIV_MSB:`CPMC_DIV_LSB]),
    .o_ratio (dec_ratio)
  );

  // Registered clock path controls from the active copy; o_cal_armed follows cal_done_arm
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_pll_on           <= 1'b0;
      o_pll_async_pd     <= 1'b1;
      o_pfd_neg          <= 1'b0;
      o_src_vco          <= 1'b0;
      o_div_bypass       <= 1'b0;
      o_div_ratio        <= 3'h2;
      o_ref_en           <= 3'h0;
      o_vco_pd           <= 1'b1;
      o_ext_to_prescaler <= 1'b0;
      o_cal_armed        <= 1'b1;
    end else if (i_clk_en) begin
      o_pll_on           <= (act_pwr == `CPMC_PWR_NORMAL); // [R1]
      o_pll_async_pd     <= (act_pwr == `CPMC_PWR_DOWN); // [R1]
      o_pfd_neg          <= act_pll[`CPMC_POL_BIT]; // [R2]
      o_src_vco          <= act_src[`CPMC_SRC_VCO_BIT]; // [R3]
      o_div_bypass       <= act_src[`CPMC_BYP_BIT]; // [R4]
      o_div_ratio        <= dec_ratio; // [R5]
      o_ref_en           <= act_ref[`CPMC_REF_MSB:`CPMC_REF_LSB];
      // VCO only runs when the PLL runs with the VCO as source
      o_vco_pd           <= !((act_pwr == `CPMC_PWR_NORMAL) && act_src[`CPMC_SRC_VCO_BIT]); // [R10]
      o_ext_to_prescaler <= (act_pwr == `CPMC_PWR_NORMAL) && !act_src[`CPMC_SRC_VCO_BIT]; // [R10]
      o_cal_armed        <= cal_done_arm;
    end
  end

  // Read data shows the staging copy; transfer register reads as zero
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else if (i_clk_en) begin
      case (i_addr)
        `CPMC_OFS_PLL_CTRL:  o_rdata <= stg_pll;
        `CPMC_OFS_CAL_CTRL:  o_rdata <= stg_cal;
        `CPMC_OFS_REF_CTRL:  o_rdata <= stg_ref;
        `CPMC_OFS_DIV_RATIO: o_rdata <= stg_div;
        `CPMC_OFS_SRC_ROUTE: o_rdata <= stg_src;
        default:             o_rdata <= 8'h00;
      endcase
    end
  end

  // Save snapshot of the active configuration for the store
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_nv_wdata <= 40'h0000000000;
      o_nv_we    <= 1'b0;
    end else if (i_clk_en) begin
      o_nv_we <= i_nv_save; // [R13]
      if (i_nv_save) begin
        o_nv_wdata <= {act_src, act_div, act_ref, act_cal, act_pll};
      end
    end
  end

endmodule

`default_nettype wire

/* cpmc_clock_path_chk.sv */
`timescale 1ns/100ps
`default_nettype none
// ****
// Clock path checker
// ****
module cpmc_clock_path_chk (
  // Clock, reset and requests
  input wire logic       i_core_clk,
  input wire logic       i_reset,
  input wire logic       i_clk_en,
  input wire logic [9:0] i_addr,
  input wire logic       i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_nv_save,
  input wire logic       i_nv_load,
  // Observed controls
  input wire logic       o_nv_we,
  input wire logic       o_pll_on,
  input wire logic       o_pll_async_pd,
  input wire logic       o_pfd_neg,
  input wire logic       o_src_vco,
  input wire logic       o_div_bypass,
  input wire logic [2:0] o_div_ratio,
  input wire logic [2:0] o_ref_en,
  input wire logic       o_vco_pd,
  input wire logic       o_ext_to_prescaler,
  input wire logic       o_cal_start,
  input wire logic       o_cal_armed
);
  // Anything that may move the active copy; kept loose so a gated strobe never false-fires
  wire hit = i_reset | i_nv_load | (i_wr & (i_addr == 10'h232) & i_wdata[0]);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  AST_PD_EXCL: assert property (o_pll_async_pd |-> !o_pll_on) else $error("PLL on while powered down");
  AST_VCO_PD: assert property (o_vco_pd == !(o_pll_on && o_src_vco)) else $error("VCO power wrong");
  AST_EXT: assert property (o_ext_to_prescaler == (o_pll_on && !o_src_vco)) else $error("Prescaler feed wrong");
  AST_RST: assert property ($past(i_reset) |-> o_pll_async_pd && !o_pll_on && !o_src_vco
    && !o_div_bypass && o_div_ratio == 3'h2 && o_cal_armed) else $error("Reset state wrong");
  AST_HOLD: assert property (!$past(hit) && !$past(hit, 2) |-> $stable({o_pll_on, o_pfd_neg,
    o_src_vco, o_div_bypass, o_div_ratio, o_ref_en})) else $error("Config moved without strobe");
  AST_RATIO: assert property (o_div_ratio inside {[3'h1:3'h6]}) else $error("Ratio out of range");
  // A frozen clock enable legally holds every pulse, so the pulse checks only look at enabled edges
  AST_CAL_PULSE: assert property (o_cal_start && i_clk_en |=> !o_cal_start) else $error("Cal pulse too long");
  AST_CAL_ARM: assert property (o_cal_start && i_clk_en |-> o_cal_armed ##1 !o_cal_armed) else $error("Cal arming wrong");
  AST_NV_WE: assert property (o_nv_we |-> $past(i_nv_save) || !$past(i_clk_en)) else $error("Store write without save");
endmodule
bind cpmc_clock_path cpmc_clock_path_chk cpmc_clock_path_chk_i (.*);
`default_nettype wire

/* cpmc_clock_path_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module cpmc_clock_path_tb;
  // ****
  // Signals
  // ****
  logic i_core_clk = 1'b0, i_reset = 1'b1, i_clk_en = 1'b1, i_wr = 1'b0, i_nv_save = 1'b0, i_nv_load = 1'b0;
  logic [9:0] i_addr = 10'h000;
  logic [7:0] i_wdata = 8'h00;
  logic [39:0] i_nv_rdata = 40'h0000000000;
  logic [39:0] nv_cap = 40'h0000000000;
  wire [7:0] o_rdata;
  wire [39:0] o_nv_wdata;
  wire [2:0] o_div_ratio, o_ref_en;
  wire o_nv_we, o_pll_on, o_pll_async_pd, o_pfd_neg, o_src_vco, o_div_bypass, o_vco_pd, o_ext_to_prescaler;
  wire o_cal_start, o_cal_armed;
  wire [12:0] outs = {o_pll_on, o_pll_async_pd, o_pfd_neg, o_src_vco, o_div_bypass, o_div_ratio, o_ref_en,
                      o_vco_pd, o_ext_to_prescaler};
  int cal_cnt = 0, nv_cnt = 0, failures = 0, samples_checked = 0;
  // Ratio per code, code 0 in the low three bits
  localparam logic [23:0] RT = 24'h4B58CA;
  cpmc_clock_path cpmc_clock_path_i (.*);
  always #50 i_core_clk = ~i_core_clk;
  // Pulses are counted so their exact cycle does not matter to the checks
  always @(posedge i_core_clk) begin
    if (o_cal_start === 1'b1) cal_cnt <= cal_cnt + 1;
    if (o_nv_we === 1'b1) begin
      nv_cnt <= nv_cnt + 1;
      nv_cap <= o_nv_wdata;
    end
  end
  // ****
  // Tasks
  // ****
  task chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h got %h", nm, e, g);
    end
  endtask
  task wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    i_wr = 1'b1;
    i_addr = a;
    i_wdata = d;
    @(negedge i_core_clk);
    i_wr = 0;
  endtask
  // Strobe, then let the outputs follow the active copy
  task go;
    wr(10'h232, 8'h01);
    @(negedge i_core_clk);
  endtask
  task rd(input logic [9:0] a, input logic [7:0] e);
    @(negedge i_core_clk);
    i_addr = a;
    @(negedge i_core_clk);
    chk("rdata", {32'h0, e}, {32'h0, o_rdata});
  endtask
  task complete_run;
    if (failures == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Watchdog, far beyond the roughly 110 cycles the sequence needs
  initial begin
    #200000;
    failures++;
    complete_run;
  end
  // ****
  // Sequence
  // ****
  initial begin
    repeat (12) @(negedge i_core_clk);
    i_reset = 1'b0;
    chk("outs", 13'h0842, outs);
    rd(10'h010, 8'h01);
    rd(10'h1E1, 8'h00);
    rd(10'h3FF, 8'h00);
    wr(10'h1E1, 8'h02);
    wr(10'h010, 8'h00);
    chk("outs", 13'h0842, outs);
    go;
    chk("outs", 13'h1240, outs);
    for (int c = 0; c < 8; c++) begin
      wr(10'h1E0, c[7:0]);
      go;
      chk("ratio", RT[c*3 +: 3], o_div_ratio);
    end
    wr(10'h010, 8'h80);
    wr(10'h1E1, 8'h01);
    wr(10'h01C, 8'h05);
    go;
    chk("outs", 13'h1557, outs);
    wr(10'h010, 8'h01);
    go;
    chk("outs", 13'h0956, outs);
    chk("cal", 0, cal_cnt);
    wr(10'h018, 8'h01);
    go;
    chk("cal", 1, cal_cnt);
    chk("armed", 0, o_cal_armed);
    go;
    wr(10'h018, 8'h00);
    go;
    chk("cal", 1, cal_cnt);
    wr(10'h018, 8'h01);
    go;
    chk("cal", 2, cal_cnt);
    i_clk_en = 1'b0;
    wr(10'h1E0, 8'h05);
    i_clk_en = 1'b1;
    rd(10'h1E0, 8'h07);
    @(negedge i_core_clk) i_nv_save = 1'b1;
    @(negedge i_core_clk) i_nv_save = 1'b0;
    repeat (2) @(negedge i_core_clk);
    chk("nv_cnt", 1, nv_cnt);
    chk("nv_wdata", 40'h0107050101, nv_cap);
    i_nv_rdata = 40'h0203070080;
    @(negedge i_core_clk) i_nv_load = 1'b1;
    @(negedge i_core_clk) i_nv_load = 1'b0;
    @(negedge i_core_clk);
    chk("outs", 13'h169C, outs);
    rd(10'h1E0, 8'h03);
    complete_run;
  end
endmodule
`default_nettype wire
